// File: csd_cfg.svh
/*
   Constants for the chip-select and wait-state decoder: register offsets,
   field positions, reset values and address field positions.
   Assumes inclusion by bare name from every file that needs a constant.
*/
`ifndef CSD_CFG_SVH
`define CSD_CFG_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define CSD_IDX_LOW0 8'hA8
`define CSD_IDX_HIGH0 8'hA9
`define CSD_IDX_CTL0 8'hAA
`define CSD_IDX_STRIDE 8'h03
`define CSD_IDX_LAST 8'hB3
`define CSD_IDX_STATUS 8'hB4

// ----------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------
`define CSD_CTL_WAIT_HI 7
`define CSD_CTL_WAIT_LO 5
`define CSD_CTL_IO_BIT 4
`define CSD_CTL_EN_BIT 3
`define CSD_CTL_WMASK 8'hF8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CSD_RST_LOW 8'h00
`define CSD_RST_HIGH0 8'hFF
`define CSD_RST_HIGHN 8'h00
`define CSD_RST_CTL0 8'hE8
`define CSD_RST_CTLN 8'h00

// ----------------------------------------------------------------------
// Address fields and peripheral range
// ----------------------------------------------------------------------
`define CSD_IO_CMP_HI 11
`define CSD_IO_CMP_LO 4
`define CSD_UPPER_HI 23
`define CSD_UPPER_LO 16
`define CSD_AVS_IDX_HI 9
`define CSD_AVS_IDX_LO 2
`define CSD_PERIPH_BIT 7
`define CSD_IO_UPPER 8'h00
`define CSD_WAIT_ZERO 3'h0

`endif

// File: csd_pkg.sv
/*
   Types for the chip-select and wait-state decoder.
   Assumes nothing of its surroundings.
*/
package csd_pkg;
   typedef enum logic [1:0] {
      CSD_IDLE = 2'b00,
      CSD_WAIT = 2'b01,
      CSD_DONE = 2'b10
   } csd_state_t;
   typedef logic [7:0] csd_byte_t;
endpackage

// File: csd_sel_match.sv
/*
   One select's qualifier: memory window or I/O slot match.
   Assumes a stable address and cycle kind from the processor bus.
*/
`timescale 1ns/1ps
`include "csd_cfg.svh"
module csd_sel_match (
   // Settings
   input wire logic [7:0] i_low_bound,
   input wire logic [7:0] i_high_bound,
   input wire logic [7:0] i_control,
   // Cycle
   input wire logic [23:0] i_addr,
   input wire logic i_mem_cycle,
   input wire logic i_io_cycle,
   input wire logic i_ram_hit,
   // Result
   output logic o_qualify
);
   import csd_pkg::*;
   logic en;
   logic is_io;
   logic mem_hit;
   logic io_hit;
   always_comb begin
      en = i_control[`CSD_CTL_EN_BIT];
      is_io = i_control[`CSD_CTL_IO_BIT];
      mem_hit = en && !is_io && i_mem_cycle && !i_ram_hit
         && (i_addr[`CSD_UPPER_HI:`CSD_UPPER_LO] >= i_low_bound)
         && (i_addr[`CSD_UPPER_HI:`CSD_UPPER_LO] <= i_high_bound);
      // Upper byte is ignored so either addressing mode and any page base match.
      io_hit = en && is_io && i_io_cycle
         && (i_addr[`CSD_IO_CMP_HI:`CSD_IO_CMP_LO] == i_low_bound)
         && !i_addr[`CSD_PERIPH_BIT];
      o_qualify = mem_hit || io_hit;
   end
endmodule // csd_sel_match

// File: csd_wait_timer.sv
/*
   Wait-state counter: holds the processor for a loaded number of cycles.
   Assumes a one-cycle start pulse while the counter is idle.
*/
`timescale 1ns/1ps
`include "csd_cfg.svh"
module csd_wait_timer #(
   parameter int WAIT_W = 3
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Control
   input wire logic i_start,
   input wire logic [WAIT_W-1:0] i_count,
   // Status
   output logic o_busy
);
   import csd_pkg::*;
   logic [WAIT_W-1:0] cnt_q;
   logic [WAIT_W-1:0] cnt_d;
   always_comb begin
      cnt_d = cnt_q;
      if (i_start) begin
         cnt_d = i_count;
      end else if (cnt_q != '0) begin
         cnt_d = cnt_q - 1'b1;
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
   assign o_busy = (cnt_q != '0);
endmodule // csd_wait_timer

// File: csd_decoder.sv
/*
   Chip-select and wait-state decoder with its Avalon-MM register slave.
   Assumes the processor holds address and cycle kind until o_cpu_wait falls,
   and drops read and write for a cycle between accesses.
*/
// Function
// - Overlapping enabled windows: only the lowest-numbered select is asserted.
// - An access owned by enabled on-chip RAM suppresses all external selects.
// - After reset select 0 covers every memory address.
// - After reset bounds of selects 1 to 3 are zero.
// - An I/O select is asserted only during I/O instructions.
// - I/O select compares address bits 11:4 with its lower bound.
// - I/O decode ignores the compatibility page base.
// - I/O select needs enable, I/O space, byte match, no better select.
// - No I/O select for low address bytes 80h to FFh.
// - Qualifying I/O access drives select, I/O request and read or write low.
// - Upper address byte is zero during every I/O operation.
// - Each select has a 3-bit wait count in control bits 7:5.
// - Each wait state stalls the processor one clock cycle.
// - Lower bound is inclusive memory limit and exact I/O compare.
// - Memory select needs enable, memory space and upper byte inside bounds.
// - Qualifying memory access drives select, memory request and strobe low.
// - A select decodes only while its enable bit is one.
`timescale 1ns/1ps
`include "csd_cfg.svh"
module csd_decoder #(
   parameter int NSEL = 4,
   parameter int WAIT_W = 3
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Avalon-MM slave
   input wire logic [9:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output logic [1:0] o_avs_response,
   // Processor bus cycle
   input wire logic [23:0] i_cpu_addr,
   input wire logic i_cpu_mem_cycle,
   input wire logic i_cpu_io_cycle,
   input wire logic i_cpu_read,
   input wire logic i_cpu_write,
   input wire logic i_ram_hit,
   output logic o_cpu_wait,
   // External bus
   output logic [23:0] o_ext_addr,
   output logic o_select_out_0_n,
   output logic o_select_out_1_n,
   output logic o_select_out_2_n,
   output logic o_select_out_3_n,
   output logic o_memory_request_n,
   output logic o_io_request_n,
   output logic o_read_n,
   output logic o_write_n
);
   import csd_pkg::*;

   // ----------------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------------
   csd_byte_t low_q [NSEL];
   csd_byte_t low_d [NSEL];
   csd_byte_t high_q [NSEL];
   csd_byte_t high_d [NSEL];
   csd_byte_t ctl_q [NSEL];
   csd_byte_t ctl_d [NSEL];
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [1:0] resp_q;
   logic [1:0] resp_d;
   logic ack_q;
   logic ack_d;
   logic [7:0] idx;
   logic req;
   logic wr_go;
   logic [NSEL-1:0] qual;
   logic [NSEL-1:0] grant;
   logic [NSEL-1:0] sel_q;
   logic [NSEL-1:0] sel_d;

   // ----------------------------------------------------------------------
   // Register access decode
   // ----------------------------------------------------------------------
   assign idx = i_avs_address[`CSD_AVS_IDX_HI:`CSD_AVS_IDX_LO];
   assign req = (i_avs_read || i_avs_write) && !ack_q;
   // Stores wait for the completing edge, when waitrequest is already low.
   assign wr_go = i_avs_write && ack_q && i_avs_byteenable[0];

   // Registers are word-indexed; each access answers one cycle after it is seen.
   // Read data load on the first edge, writes store on the completing edge.
   always_comb begin
      logic [7:0] rel;
      logic [1:0] sub;
      logic [7:0] num;
      logic [7:0] field;
      rel = idx - `CSD_IDX_LOW0;
      sub = 2'h0;
      num = 8'h00;
      field = 8'h00;
      for (int s = 0; s < NSEL; s++) begin
         low_d[s] = low_q[s];
         high_d[s] = high_q[s];
         ctl_d[s] = ctl_q[s];
      end
      rdata_d = 32'h0000_0000;
      resp_d = 2'h0;
      ack_d = req;
      if (idx >= `CSD_IDX_LOW0 && idx <= `CSD_IDX_LAST) begin
         num = rel / `CSD_IDX_STRIDE;
         sub = 2'(rel % `CSD_IDX_STRIDE);
         for (int s = 0; s < NSEL; s++) begin
            if (num == 8'(s)) begin
               case (sub)
                  2'h0: begin
                     field = low_q[s];
                     if (wr_go) begin
                        low_d[s] = i_avs_writedata[7:0];
                     end
                  end
                  2'h1: begin
                     field = high_q[s];
                     if (wr_go) begin
                        high_d[s] = i_avs_writedata[7:0];
                     end
                  end
                  default: begin
                     // Reserved bits 2:0 hold zero.
                     field = ctl_q[s];
                     if (wr_go) begin
                        ctl_d[s] = i_avs_writedata[7:0] & `CSD_CTL_WMASK;
                     end
                  end
               endcase
            end
         end
         if (req) begin
            rdata_d = {24'h000000, field};
         end
      end else if (idx == `CSD_IDX_STATUS) begin
         if (req) begin
            rdata_d = {23'h000000, o_cpu_wait, 4'h0, sel_q};
         end
      end else if (req) begin
         resp_d = 2'h2;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         for (int s = 0; s < NSEL; s++) begin
            low_q[s] <= `CSD_RST_LOW;
            high_q[s] <= (s == 0) ? `CSD_RST_HIGH0 : `CSD_RST_HIGHN;
            ctl_q[s] <= (s == 0) ? `CSD_RST_CTL0 : `CSD_RST_CTLN;
         end
         rdata_q <= 32'h0000_0000;
         resp_q <= 2'h0;
         ack_q <= 1'b0;
      end else begin
         for (int s = 0; s < NSEL; s++) begin
            low_q[s] <= low_d[s];
            high_q[s] <= high_d[s];
            ctl_q[s] <= ctl_d[s];
         end
         rdata_q <= rdata_d;
         resp_q <= resp_d;
         ack_q <= ack_d;
      end
   end

   // ----------------------------------------------------------------------
   // Avalon-MM answer
   // ----------------------------------------------------------------------
   assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;
   assign o_avs_readdata = rdata_q;
   assign o_avs_response = resp_q;

   // ----------------------------------------------------------------------
   // Select qualification and priority
   // ----------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NSEL; g++) begin : g_sel
         csd_sel_match u_match (
            .i_low_bound(low_q[g]),
            .i_high_bound(high_q[g]),
            .i_control(ctl_q[g]),
            .i_addr(i_cpu_addr),
            .i_mem_cycle(i_cpu_mem_cycle),
            .i_io_cycle(i_cpu_io_cycle),
            .i_ram_hit(i_ram_hit),
            .o_qualify(qual[g])
         );
      end
   endgenerate

   // Lowest index wins; the one-hot grant keeps at most one select low.
   always_comb begin
      logic taken;
      taken = 1'b0;
      grant = '0;
      for (int s = 0; s < NSEL; s++) begin
         if (qual[s] && !taken) begin
            grant[s] = 1'b1;
            taken = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Wait-state sequencing
   // ----------------------------------------------------------------------
   csd_state_t state_q;
   csd_state_t state_d;
   logic [WAIT_W-1:0] wcount;
   logic wstart;
   logic wbusy;
   logic cycle_on;
   logic [WAIT_W-1:0] wload;

   assign cycle_on = (i_cpu_mem_cycle || i_cpu_io_cycle) && (i_cpu_read || i_cpu_write);
   // The start cycle is the first stall cycle, so the timer runs one less.
   assign wload = wcount - 1'b1;

   always_comb begin
      wcount = `CSD_WAIT_ZERO;
      for (int s = 0; s < NSEL; s++) begin
         if (grant[s]) begin
            wcount = ctl_q[s][`CSD_CTL_WAIT_HI:`CSD_CTL_WAIT_LO];
         end
      end
   end

   always_comb begin
      state_d = state_q;
      wstart = 1'b0;
      case (state_q)
         CSD_IDLE: begin
            if (cycle_on && grant != '0 && wcount != `CSD_WAIT_ZERO) begin
               wstart = 1'b1;
               state_d = CSD_WAIT;
            end else if (cycle_on) begin
               state_d = CSD_DONE;
            end
         end
         CSD_WAIT: begin
            if (!wbusy) begin
               state_d = CSD_DONE;
            end
         end
         CSD_DONE: begin
            if (!cycle_on) begin
               state_d = CSD_IDLE;
            end
         end
         default: begin
            state_d = CSD_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         state_q <= CSD_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   csd_wait_timer #(
      .WAIT_W(WAIT_W)
   ) u_wait (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_start(wstart),
      .i_count(wload),
      .o_busy(wbusy)
   );

   // One stall cycle per programmed wait state, then the cycle completes.
   assign o_cpu_wait = wstart || (state_q == CSD_WAIT && wbusy);

   // ----------------------------------------------------------------------
   // External strobes
   // ----------------------------------------------------------------------
   logic memory_request_n_q;
   logic memory_request_n_d;
   logic io_request_n_q;
   logic io_request_n_d;
   logic rd_q;
   logic rd_d;
   logic wr_q;
   logic wr_d;
   logic [23:0] addr_q;
   logic [23:0] addr_d;

   always_comb begin
      // A select only drives while the processor has a read or write under way.
      sel_d = cycle_on ? grant : '0;
      memory_request_n_d = i_cpu_mem_cycle && !i_ram_hit && (sel_d != '0);
      io_request_n_d = i_cpu_io_cycle && (sel_d != '0);
      rd_d = (memory_request_n_d || io_request_n_d) && i_cpu_read;
      wr_d = (memory_request_n_d || io_request_n_d) && i_cpu_write && !i_cpu_read;
      addr_d = i_cpu_addr;
      if (i_cpu_io_cycle) begin
         addr_d[`CSD_UPPER_HI:`CSD_UPPER_LO] = `CSD_IO_UPPER;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         sel_q <= '0;
         memory_request_n_q <= 1'b0;
         io_request_n_q <= 1'b0;
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         addr_q <= 24'h000000;
      end else begin
         sel_q <= sel_d;
         memory_request_n_q <= memory_request_n_d;
         io_request_n_q <= io_request_n_d;
         rd_q <= rd_d;
         wr_q <= wr_d;
         addr_q <= addr_d;
      end
   end

   // ----------------------------------------------------------------------
   // Output pins
   // ----------------------------------------------------------------------
   assign o_select_out_0_n = ~sel_q[0];
   assign o_select_out_1_n = ~sel_q[1];
   assign o_select_out_2_n = ~sel_q[2];
   assign o_select_out_3_n = ~sel_q[3];
   assign o_memory_request_n = ~memory_request_n_q;
   assign o_io_request_n = ~io_request_n_q;
   assign o_read_n = ~rd_q;
   assign o_write_n = ~wr_q;
   assign o_ext_addr = addr_q;

endmodule // csd_decoder

// File: csd_decoder_sva.sv
/*
   Port checks for the chip-select decoder.
   Assumes it is bound onto csd_decoder and sees only its ports.
*/
`timescale 1ns/1ps
module csd_decoder_sva (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Processor side
   input wire logic [23:0] i_cpu_addr,
   input wire logic i_cpu_mem_cycle,
   input wire logic i_cpu_io_cycle,
   input wire logic i_cpu_read,
   input wire logic i_cpu_write,
   input wire logic i_ram_hit,
   input wire logic o_cpu_wait,
   // External side
   input wire logic [23:0] o_ext_addr,
   input wire logic o_select_out_0_n,
   input wire logic o_select_out_1_n,
   input wire logic o_select_out_2_n,
   input wire logic o_select_out_3_n,
   input wire logic o_memory_request_n,
   input wire logic o_io_request_n,
   input wire logic o_read_n,
   input wire logic o_write_n
);
   logic [3:0] sel_n;
   logic [3:0] run_d;
   logic [3:0] run_q;
   assign sel_n = {o_select_out_3_n, o_select_out_2_n, o_select_out_1_n, o_select_out_0_n};
   // Length of the current stall run.
   always_comb begin
      run_d = o_cpu_wait ? run_q + 4'h1 : 4'h0;
   end
   always_ff @(posedge i_clk) begin
      run_q <= i_rst_b ? run_d : 4'h0;
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   a_one_select_low: assert property ($countones(~sel_n) <= 1)
      else $error("two selects low");
   a_idle_all_high: assert property (!((i_cpu_mem_cycle | i_cpu_io_cycle) & (i_cpu_read | i_cpu_write))
      |=> sel_n == 4'hF) else $error("select low without cycle");
   a_ram_kills_sel: assert property (i_ram_hit |=> sel_n == 4'hF && o_memory_request_n)
      else $error("select during ram hit");
   a_periph_no_io: assert property (i_cpu_io_cycle && i_cpu_addr[7] |=> sel_n == 4'hF)
      else $error("io select in peripheral range");
   a_io_upper_zero: assert property (i_cpu_io_cycle |=> o_ext_addr[23:16] == 8'h00)
      else $error("upper byte not zero on io");
   a_io_needs_io: assert property (sel_n != 4'hF && !o_io_request_n |-> $past(i_cpu_io_cycle))
      else $error("io request outside io cycle");
   a_mem_strobe_low: assert property (sel_n != 4'hF && $past(i_cpu_mem_cycle)
      |-> !o_memory_request_n && o_io_request_n) else $error("memory strobes wrong");
   a_rw_strobe_match: assert property (sel_n != 4'hF |-> o_read_n == !$past(i_cpu_read)
      && o_write_n == !$past(i_cpu_write)) else $error("read or write strobe wrong");
   a_wait_at_most: assert property (run_q <= 4'h7)
      else $error("stall longer than seven");
   cover property (!o_select_out_2_n && !o_io_request_n);
   cover property (run_q == 4'h7);
   cover property ($fell(o_select_out_1_n));
endmodule // csd_decoder_sva

// File: csd_ext_dev.sv
/*
   External device model: latches the address of each selected access.
   Assumes active-low selects from the decoder.
*/
`timescale 1ns/1ps
module csd_ext_dev (
   // Clock
   input wire logic i_clk,
   // Bus
   input wire logic [3:0] i_sel_n,
   input wire logic [23:0] i_addr,
   // Capture
   output logic [23:0] o_last_addr
);
   logic [23:0] addr_d;
   always_comb begin
      addr_d = (i_sel_n != 4'hF) ? i_addr : o_last_addr;
   end
   always_ff @(posedge i_clk) begin
      o_last_addr <= addr_d;
   end
endmodule // csd_ext_dev

// File: test_chip_select_wait_decoder.sv
/*
   Bench for the chip-select decoder: register and processor-cycle tests.
   Assumes the decoder, its header and the device model are compiled first.
*/
`timescale 1ns/1ps
module test_chip_select_wait_decoder;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [9:0] av_a = 10'h000;
   logic av_rd = 1'b0;
   logic av_wr = 1'b0;
   logic [31:0] av_wd = 32'h0;
   logic [31:0] av_q;
   logic av_wait;
   logic [1:0] av_rsp;
   logic [23:0] c_a = 24'h0;
   logic c_mem = 1'b0;
   logic c_io = 1'b0;
   logic c_rd = 1'b0;
   logic c_wr = 1'b0;
   logic ram = 1'b0;
   logic c_wait;
   logic [23:0] x_a;
   logic [23:0] dev_a;
   logic [3:0] sel_n;
   logic [3:0] strb;
   logic [31:0] rd;
   logic [1:0] rsp;
   int error_cnt = 0;
   int samples_checked = 0;
   int cyc = 0;
   int i;
   csd_decoder dut (.i_clk(clk), .i_rst_b(rst_b), .i_avs_address(av_a), .i_avs_read(av_rd), .i_avs_write(av_wr),
      .i_avs_writedata(av_wd), .i_avs_byteenable(4'hF), .o_avs_readdata(av_q), .o_avs_waitrequest(av_wait),
      .o_avs_response(av_rsp), .i_cpu_addr(c_a), .i_cpu_mem_cycle(c_mem), .i_cpu_io_cycle(c_io),
      .i_cpu_read(c_rd), .i_cpu_write(c_wr), .i_ram_hit(ram), .o_cpu_wait(c_wait), .o_ext_addr(x_a),
      .o_select_out_0_n(sel_n[0]), .o_select_out_1_n(sel_n[1]), .o_select_out_2_n(sel_n[2]),
      .o_select_out_3_n(sel_n[3]), .o_memory_request_n(strb[3]), .o_io_request_n(strb[2]),
      .o_read_n(strb[1]), .o_write_n(strb[0]));
   csd_ext_dev dev (.i_clk(clk), .i_sel_n(sel_n), .i_addr(x_a), .o_last_addr(dev_a));
   always #25 clk = ~clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Avalon access; holds the request until waitrequest is seen low.
   task automatic av(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge clk);
      av_rd <= !w;
      av_wr <= w;
      av_a <= {idx, 2'b00};
      av_wd <= {24'h0, wd};
      do begin
         @(posedge clk);
      end while (av_wait !== 1'b0);
      rd = av_q;
      rsp = av_rsp;
      av_rd <= 1'b0;
      av_wr <= 1'b0;
   endtask
   // One processor cycle; es is the expected active-low select pattern.
   task automatic cpu(input logic io, input logic w, input logic [23:0] a, input logic r, input logic [3:0] es,
      input int ew);
      int k;
      int n;
      logic [7:0] seen;
      n = 0;
      seen = 8'h00;
      @(posedge clk);
      c_a <= a;
      c_mem <= !io;
      c_io <= io;
      c_rd <= !w;
      c_wr <= w;
      ram <= r;
      for (k = 0; k < 20; k++) begin
         @(negedge clk);
         if (k == 1) seen = {sel_n, strb};
         if (c_wait === 1'b1) n++;
         else if (k >= 1) break;
      end
      chk(seen[7:4], es);
      chk(n, ew);
      if (es != 4'hF) chk(seen[3:0], {io, !io, w, !w});
      @(posedge clk);
      c_mem <= 1'b0;
      c_io <= 1'b0;
      c_rd <= 1'b0;
      c_wr <= 1'b0;
      ram <= 1'b0;
      // The device model latches on the edge after the select falls.
      @(negedge clk);
      if (es != 4'hF) chk(dev_a, io ? {8'h00, a[15:0]} : a);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         wrap_up();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      for (i = 0; i < 12; i++) begin
         av(1'b0, 8'hA8 + 8'(i), 8'h00);
         chk(rd, (i == 1) ? 32'hFF : (i == 2) ? 32'hE8 : 32'h0);
      end
      // Status of an idle bus: no select asserted and no stall.
      av(1'b0, 8'hB4, 8'h00);
      chk(rd, 32'h0);
      chk(rsp, 32'h0);
      cpu(1'b0, 1'b0, 24'hFEDCBA, 1'b0, 4'hE, 7);
      $display("reset state test done");
      av(1'b1, 8'hAD, 8'h4F);
      av(1'b0, 8'hAD, 8'h00);
      chk(rd, 32'h48);
      av(1'b1, 8'hAB, 8'h10);
      av(1'b1, 8'hAC, 8'h20);
      av(1'b1, 8'hA9, 8'h1F);
      cpu(1'b0, 1'b0, 24'h150000, 1'b0, 4'hE, 7);
      cpu(1'b0, 1'b1, 24'h20FFFF, 1'b0, 4'hD, 2);
      cpu(1'b0, 1'b0, 24'h150000, 1'b1, 4'hF, 0);
      av(1'b1, 8'hAA, 8'hE0);
      cpu(1'b0, 1'b0, 24'h100000, 1'b0, 4'hD, 2);
      cpu(1'b0, 1'b0, 24'h0F0000, 1'b0, 4'hF, 0);
      $display("memory select test done");
      av(1'b1, 8'hB0, 8'h38);
      av(1'b1, 8'hAE, 8'h35);
      cpu(1'b1, 1'b1, 24'hAB0350, 1'b0, 4'hB, 1);
      cpu(1'b1, 1'b0, 24'h7F0357, 1'b0, 4'hB, 1);
      cpu(1'b0, 1'b0, 24'h000350, 1'b0, 4'hF, 0);
      cpu(1'b1, 1'b0, 24'h000360, 1'b0, 4'hF, 0);
      av(1'b1, 8'hAE, 8'h38);
      cpu(1'b1, 1'b0, 24'h000380, 1'b0, 4'hF, 0);
      $display("io select test done");
      av(1'b0, 8'hB5, 8'h00);
      chk(rsp, 32'h2);
      chk(rd, 32'h0);
      $display("unmapped access test done");
      wrap_up();
   end
endmodule // test_chip_select_wait_decoder
bind csd_decoder csd_decoder_sva u_sva (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_cpu_addr(i_cpu_addr),
   .i_cpu_mem_cycle(i_cpu_mem_cycle), .i_cpu_io_cycle(i_cpu_io_cycle), .i_cpu_read(i_cpu_read),
   .i_cpu_write(i_cpu_write), .i_ram_hit(i_ram_hit), .o_cpu_wait(o_cpu_wait), .o_ext_addr(o_ext_addr),
   .o_select_out_0_n(o_select_out_0_n), .o_select_out_1_n(o_select_out_1_n), .o_select_out_2_n(o_select_out_2_n),
   .o_select_out_3_n(o_select_out_3_n), .o_memory_request_n(o_memory_request_n), .o_io_request_n(o_io_request_n),
   .o_read_n(o_read_n), .o_write_n(o_write_n));
